// >>> src/dmacd_defs.svh
// Register offsets, field positions, reset values and cause codes of the channel
`ifndef DMACD_DEFS_SVH
`define DMACD_DEFS_SVH

// Byte offsets on the register bus: low word of each 64-bit channel register, then the two 32-bit global registers
`define DMACD_OFF_PTR 8'h00
`define DMACD_OFF_SRC 8'h08
`define DMACD_OFF_DST 8'h10
`define DMACD_OFF_CNT 8'h18
`define DMACD_OFF_SINC 8'h20
`define DMACD_OFF_DINC 8'h28
`define DMACD_OFF_CTRL 8'h30
`define DMACD_OFF_STAT 8'h38
`define DMACD_OFF_MCTRL 8'h40
`define DMACD_OFF_PIN_CONFIG_REG 8'h44

// Channel control fields
`define DMACD_CTRL_ACT 0
`define DMACD_CTRL_REV 1
`define DMACD_CTRL_SHORT 2
`define DMACD_CTRL_DONE_IE 3
`define DMACD_CTRL_ERR_IE 4
`define DMACD_CTRL_CEND_IE 5

// Channel status fields
`define DMACD_STAT_CAUSE_LSB 0
`define DMACD_STAT_DONE 8
`define DMACD_STAT_CEND 9

// Global master control and pin configuration fields
`define DMACD_MCTRL_EN 0
`define DMACD_PIN_CONFIG_REG_SEL_W 2

// Error causes in the low four status bits
`define DMACD_ERR_RD 4'h1
`define DMACD_ERR_WR 4'h2
`define DMACD_ERR_DESC 4'h3
`define DMACD_ERR_CFG 4'h4

// Descriptor geometry
`define DMACD_DESC_FULL 3'h7
`define DMACD_DESC_SHORT 3'h3
`define DMACD_DWORD_BYTES 64'h0000_0000_0000_0008

`define DMACD_RST_64 64'h0000_0000_0000_0000

`endif

// >>> src/dmacd_pkg.sv
// Types shared by the descriptor-chain channel
package dmacd_pkg;
  typedef enum logic [2:0] {
    DMACD_IDLE,
    DMACD_FETCH,
    DMACD_CHECK,
    DMACD_READ,
    DMACD_WRITE
  } dmacd_state_e;
endpackage

// >>> src/dmacd_byte_rev.sv
// Byte-order reversal of one data word
`timescale 1ns/1ps
module dmacd_byte_rev #(
  parameter int BYTES = 8
) (
  input wire logic [BYTES*8-1:0] data_i,
  input wire logic enable_i,
  output logic [BYTES*8-1:0] data_o
);
  logic [BYTES*8-1:0] rev;

  // Byte k moves to byte BYTES-1-k
  always_comb
  begin
    rev = '0;
    for (int k = 0; k < BYTES; k++)
    begin
      rev[k*8 +: 8] = data_i[(BYTES-1-k)*8 +: 8];
    end
    data_o = enable_i ? rev : data_i;
  end
endmodule

// >>> src/dmacd_channel.sv
// One DMA channel with register-only transfer and descriptor-chain operation
// What this block does
// - With reverse bit set, each read double word is written byte-reversed.
// - Setting the transfer-active bit starts data movement.
// - Normal end sets the done flag; interrupt if its enable is set.
// - An error records its cause in status bits 3..0 and stops.
// - Short descriptors load four double words, keeping increments, control, status.
// - Full descriptors load words one to seven, and a nonzero pointer word, into channel registers.
// - Descriptor layout is pointer, source, destination, count, increments, control, status.
// - Nonzero pointer and finished count fetch the next descriptor and continue.
// - A full descriptor load overwrites the status register.
// - Writing the first descriptor address loads it, then transfers by it.
// - A zero next-pointer field leaves the pointer register unchanged.
// - Zero test happens only on low-half pointer writes; nonzero launches the chain.
// - After the whole chain the chain-end flag is set; interrupt if enabled.
// - In chains every finished descriptor sets the done flag; interrupt if enabled.
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "dmacd_defs.svh"
module dmacd_channel #(
  parameter int DATA_W = 64
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Avalon-MM register slave, byte addressed
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Internal system bus master
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [63:0] mem_addr_o,
  output logic [DATA_W-1:0] mem_wdata_o,
  input wire logic [DATA_W-1:0] mem_rdata_i,
  input wire logic mem_ack_i,
  input wire logic mem_err_i,
  // Channel interrupt and request source selection
  output logic irq_o,
  output logic [`DMACD_PIN_CONFIG_REG_SEL_W-1:0] req_sel_o
);
  logic [63:0] ptr_reg, src_reg, dst_reg, cnt_reg, sinc_reg, dinc_reg, ctrl_reg, stat_reg;
  logic mctrl_en_reg;
  logic [`DMACD_PIN_CONFIG_REG_SEL_W-1:0] pin_config_reg_reg;
  logic [DATA_W-1:0] data_reg;
  logic [DATA_W-1:0] data_swapped;
  logic chain_reg, last_reg;
  logic [2:0] idx_reg, idx_last_reg;
  dmacd_pkg::dmacd_state_e state_reg;
  logic bus_wr, bus_hi, bus_low_ptr, start_reg, start_chain;
  logic [7:0] word_addr;
  logic [63:0] ptr_next, cnt_next;

  // Merge one 32-bit half into a 64-bit register under byte enables
  function automatic logic [63:0] wmerge(input logic [63:0] old, input logic hi,
                                         input logic [31:0] d, input logic [3:0] be);
    logic [63:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        if (hi)
          r[32 + b*8 +: 8] = d[b*8 +: 8];
        else
          r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // A write takes effect only in the cycle the slave drops waitrequest
  assign bus_wr = avs_write_i && !avs_waitrequest_o;
  assign bus_hi = avs_address_i[2];
  assign word_addr = {avs_address_i[7:3], 3'b000};
  assign bus_low_ptr = bus_wr && !bus_hi && word_addr == `DMACD_OFF_PTR;
  assign ptr_next = wmerge(ptr_reg, 1'b0, avs_writedata_i, avs_byteenable_i);
  // Register-only start: active bit written while idle
  assign start_reg = bus_wr && !bus_hi && word_addr == `DMACD_OFF_CTRL
                     && avs_byteenable_i[0] && avs_writedata_i[`DMACD_CTRL_ACT]
                     && state_reg == dmacd_pkg::DMACD_IDLE;
  // Only a low-half write is tested, so a two-store update launches once
  assign start_chain = bus_low_ptr && ptr_next != `DMACD_RST_64
                       && state_reg == dmacd_pkg::DMACD_IDLE;
  assign cnt_next = (cnt_reg > `DMACD_DWORD_BYTES) ? cnt_reg - `DMACD_DWORD_BYTES
                                                   : `DMACD_RST_64;

  dmacd_byte_rev #(
    .BYTES(DATA_W/8)
  ) u_rev (
    .data_i(data_reg),
    .enable_i(ctrl_reg[`DMACD_CTRL_REV]),
    .data_o(data_swapped)
  );

  // Avalon slave handshake: one wait cycle, then a one-cycle answer
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
      if (avs_read_i && avs_waitrequest_o)
      begin
        if (avs_address_i == `DMACD_OFF_MCTRL)
          avs_readdata_o <= {31'h0000_0000, mctrl_en_reg};
        else if (avs_address_i == `DMACD_OFF_PIN_CONFIG_REG)
          avs_readdata_o <= {30'h0000_0000, pin_config_reg_reg};
        else if (word_addr == `DMACD_OFF_PTR)
          avs_readdata_o <= bus_hi ? ptr_reg[63:32] : ptr_reg[31:0];
        else if (word_addr == `DMACD_OFF_SRC)
          avs_readdata_o <= bus_hi ? src_reg[63:32] : src_reg[31:0];
        else if (word_addr == `DMACD_OFF_DST)
          avs_readdata_o <= bus_hi ? dst_reg[63:32] : dst_reg[31:0];
        else if (word_addr == `DMACD_OFF_CNT)
          avs_readdata_o <= bus_hi ? cnt_reg[63:32] : cnt_reg[31:0];
        else if (word_addr == `DMACD_OFF_SINC)
          avs_readdata_o <= bus_hi ? sinc_reg[63:32] : sinc_reg[31:0];
        else if (word_addr == `DMACD_OFF_DINC)
          avs_readdata_o <= bus_hi ? dinc_reg[63:32] : dinc_reg[31:0];
        else if (word_addr == `DMACD_OFF_CTRL)
          avs_readdata_o <= bus_hi ? ctrl_reg[63:32] : ctrl_reg[31:0];
        else if (word_addr == `DMACD_OFF_STAT)
          avs_readdata_o <= bus_hi ? stat_reg[63:32] : stat_reg[31:0];
        else
          avs_readdata_o <= 32'h0000_0000; // Unmapped reads return zero
      end
    end
  end

  // Global registers; the request select only steers the pin mux outside
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      mctrl_en_reg <= 1'b0;
      pin_config_reg_reg <= '0;
    end
    else if (ce_i && bus_wr && avs_byteenable_i[0])
    begin
      if (avs_address_i == `DMACD_OFF_MCTRL)
        mctrl_en_reg <= avs_writedata_i[`DMACD_MCTRL_EN];
      else if (avs_address_i == `DMACD_OFF_PIN_CONFIG_REG)
        pin_config_reg_reg <= avs_writedata_i[`DMACD_PIN_CONFIG_REG_SEL_W-1:0];
    end
  end
  assign req_sel_o = pin_config_reg_reg;

  // Channel registers: software writes first, hardware updates after, so sets win
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      ptr_reg <= `DMACD_RST_64;
      src_reg <= `DMACD_RST_64;
      dst_reg <= `DMACD_RST_64;
      cnt_reg <= `DMACD_RST_64;
      sinc_reg <= `DMACD_RST_64;
      dinc_reg <= `DMACD_RST_64;
      ctrl_reg <= `DMACD_RST_64;
      stat_reg <= `DMACD_RST_64;
      data_reg <= '0;
    end
    else if (ce_i)
    begin
      if (bus_wr)
      begin
        if (word_addr == `DMACD_OFF_PTR)
          ptr_reg <= wmerge(ptr_reg, bus_hi, avs_writedata_i, avs_byteenable_i);
        else if (word_addr == `DMACD_OFF_SRC)
          src_reg <= wmerge(src_reg, bus_hi, avs_writedata_i, avs_byteenable_i);
        else if (word_addr == `DMACD_OFF_DST)
          dst_reg <= wmerge(dst_reg, bus_hi, avs_writedata_i, avs_byteenable_i);
        else if (word_addr == `DMACD_OFF_CNT)
          cnt_reg <= wmerge(cnt_reg, bus_hi, avs_writedata_i, avs_byteenable_i);
        else if (word_addr == `DMACD_OFF_SINC)
          sinc_reg <= wmerge(sinc_reg, bus_hi, avs_writedata_i, avs_byteenable_i);
        else if (word_addr == `DMACD_OFF_DINC)
          dinc_reg <= wmerge(dinc_reg, bus_hi, avs_writedata_i, avs_byteenable_i);
        else if (word_addr == `DMACD_OFF_CTRL && state_reg == dmacd_pkg::DMACD_IDLE)
          ctrl_reg <= wmerge(ctrl_reg, bus_hi, avs_writedata_i, avs_byteenable_i);
        else if (word_addr == `DMACD_OFF_STAT)
          stat_reg <= wmerge(stat_reg, bus_hi, avs_writedata_i, avs_byteenable_i);
      end
      if (start_chain)
        ctrl_reg[`DMACD_CTRL_ACT] <= 1'b1;
      // Missing master enable is a configuration error, nothing moves
      if ((start_reg || start_chain) && !mctrl_en_reg)
      begin
        stat_reg[`DMACD_STAT_CAUSE_LSB +: 4] <= `DMACD_ERR_CFG;
        ctrl_reg[`DMACD_CTRL_ACT] <= 1'b0;
      end
      if (mem_req_o && mem_ack_i)
      begin
        case (state_reg)
          // Descriptor words land in order 0..7 in their registers
          dmacd_pkg::DMACD_FETCH:
          begin
            case (idx_reg)
              3'd0: if (mem_rdata_i[63:0] != `DMACD_RST_64) ptr_reg <= mem_rdata_i[63:0];
              3'd1: src_reg <= mem_rdata_i[63:0];
              3'd2: dst_reg <= mem_rdata_i[63:0];
              3'd3: cnt_reg <= mem_rdata_i[63:0];
              3'd4: sinc_reg <= mem_rdata_i[63:0];
              3'd5: dinc_reg <= mem_rdata_i[63:0];
              3'd6: ctrl_reg <= mem_rdata_i[63:0] | 64'h0000_0000_0000_0001;
              default: stat_reg <= mem_rdata_i[63:0];
            endcase
          end
          dmacd_pkg::DMACD_READ:
          begin
            data_reg <= mem_rdata_i;
            src_reg <= src_reg + sinc_reg;
          end
          dmacd_pkg::DMACD_WRITE:
          begin
            dst_reg <= dst_reg + dinc_reg;
            cnt_reg <= cnt_next;
          end
          default:
          begin
          end
        endcase
      end
      // Bus error: record the cause and stop
      if (mem_req_o && mem_err_i)
      begin
        ctrl_reg[`DMACD_CTRL_ACT] <= 1'b0;
        if (state_reg == dmacd_pkg::DMACD_FETCH)
          stat_reg[`DMACD_STAT_CAUSE_LSB +: 4] <= `DMACD_ERR_DESC;
        else if (state_reg == dmacd_pkg::DMACD_READ)
          stat_reg[`DMACD_STAT_CAUSE_LSB +: 4] <= `DMACD_ERR_RD;
        else
          stat_reg[`DMACD_STAT_CAUSE_LSB +: 4] <= `DMACD_ERR_WR;
      end
      // End of one descriptor's data, or of a register-only transfer
      if (state_reg == dmacd_pkg::DMACD_CHECK && cnt_reg == `DMACD_RST_64)
      begin
        stat_reg[`DMACD_STAT_DONE] <= 1'b1;
        if (!chain_reg || last_reg)
          ctrl_reg[`DMACD_CTRL_ACT] <= 1'b0;
        if (chain_reg && last_reg)
          stat_reg[`DMACD_STAT_CEND] <= 1'b1;
      end
    end
  end

  // Sequencer: fetch descriptor, then read/write double words until count is zero
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= dmacd_pkg::DMACD_IDLE;
      chain_reg <= 1'b0;
      last_reg <= 1'b0;
      idx_reg <= 3'd0;
      idx_last_reg <= `DMACD_DESC_FULL;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= `DMACD_RST_64;
      mem_wdata_o <= '0;
    end
    else if (ce_i)
    begin
      case (state_reg)
        dmacd_pkg::DMACD_IDLE:
        begin
          if (start_chain && mctrl_en_reg)
          begin
            chain_reg <= 1'b1;
            last_reg <= 1'b0;
            idx_reg <= 3'd0;
            // Short mode freezes increments, control and status
            idx_last_reg <= ctrl_reg[`DMACD_CTRL_SHORT] ? `DMACD_DESC_SHORT
                                                        : `DMACD_DESC_FULL;
            mem_req_o <= 1'b1;
            mem_we_o <= 1'b0;
            mem_addr_o <= ptr_next;
            state_reg <= dmacd_pkg::DMACD_FETCH;
          end
          else if (start_reg && mctrl_en_reg)
          begin
            chain_reg <= 1'b0;
            state_reg <= dmacd_pkg::DMACD_CHECK;
          end
        end
        dmacd_pkg::DMACD_FETCH:
        begin
          if (mem_err_i)
          begin
            mem_req_o <= 1'b0;
            state_reg <= dmacd_pkg::DMACD_IDLE;
          end
          else if (mem_ack_i)
          begin
            if (idx_reg == 3'd0)
              last_reg <= mem_rdata_i[63:0] == `DMACD_RST_64;
            if (idx_reg == idx_last_reg)
            begin
              mem_req_o <= 1'b0;
              state_reg <= dmacd_pkg::DMACD_CHECK;
            end
            else
            begin
              idx_reg <= idx_reg + 3'd1;
              mem_addr_o <= mem_addr_o + `DMACD_DWORD_BYTES;
            end
          end
        end
        dmacd_pkg::DMACD_CHECK:
        begin
          if (cnt_reg != `DMACD_RST_64)
          begin
            mem_req_o <= 1'b1;
            mem_we_o <= 1'b0;
            mem_addr_o <= src_reg;
            state_reg <= dmacd_pkg::DMACD_READ;
          end
          else if (chain_reg && !last_reg)
          begin
            idx_reg <= 3'd0;
            mem_req_o <= 1'b1;
            mem_we_o <= 1'b0;
            mem_addr_o <= ptr_reg;
            state_reg <= dmacd_pkg::DMACD_FETCH;
          end
          else
            state_reg <= dmacd_pkg::DMACD_IDLE;
        end
        dmacd_pkg::DMACD_READ:
        begin
          if (mem_err_i)
          begin
            mem_req_o <= 1'b0;
            state_reg <= dmacd_pkg::DMACD_IDLE;
          end
          else if (mem_ack_i)
          begin
            // Drop the request one cycle while the word turns round
            mem_req_o <= 1'b0;
            state_reg <= dmacd_pkg::DMACD_WRITE;
          end
        end
        dmacd_pkg::DMACD_WRITE:
        begin
          if (!mem_req_o)
          begin
            mem_req_o <= 1'b1;
            mem_we_o <= 1'b1;
            mem_addr_o <= dst_reg;
            mem_wdata_o <= data_swapped;
          end
          else if (mem_err_i || mem_ack_i)
          begin
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            state_reg <= mem_err_i ? dmacd_pkg::DMACD_IDLE : dmacd_pkg::DMACD_CHECK;
          end
        end
        default:
          state_reg <= dmacd_pkg::DMACD_IDLE;
      endcase
    end
  end

  // Level interrupt from status flags gated by their enables
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      irq_o <= 1'b0;
    else if (ce_i)
      irq_o <= (stat_reg[`DMACD_STAT_DONE] && ctrl_reg[`DMACD_CTRL_DONE_IE])
               || (stat_reg[3:0] != 4'h0 && ctrl_reg[`DMACD_CTRL_ERR_IE])
               || (stat_reg[`DMACD_STAT_CEND] && ctrl_reg[`DMACD_CTRL_CEND_IE]);
  end
endmodule

// >>> dv/dmacd_channel_checker.sv
// Concurrent checks on the ports of the descriptor-chain channel
`timescale 1ns/1ps
module dmacd_channel_checker #(
  parameter int DATA_W = 64
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [63:0] mem_addr_o,
  input wire logic [DATA_W-1:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic mem_err_i,
  input wire logic irq_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // Descriptor words arrive back to back while the request stays up
  sequence s_read_ack;
    mem_req_o && !mem_we_o && mem_ack_i;
  endsequence
  sequence s_read_req;
    mem_req_o && !mem_we_o;
  endsequence

  // Register bus answers exactly one cycle after a request is seen
  a_wait_one_cycle: assert property ((ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o)
    |=> !avs_waitrequest_o) else $error("waitrequest not low one cycle after request");
  a_wait_single_pulse: assert property ((ce_i && !avs_waitrequest_o) |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_wait_at_rest: assert property ((ce_i && !avs_read_i && !avs_write_i) |=> avs_waitrequest_o)
    else $error("waitrequest dropped without a request");
  a_reset_idle_outputs: assert property ($fell(sys_rst_i) |-> !mem_req_o && !irq_o)
    else $error("channel not idle after reset");
  // A bus request must not move before it is answered
  a_mem_req_hold: assert property ((ce_i && mem_req_o && !mem_ack_i && !mem_err_i) |=>
    (mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o)))
    else $error("internal bus request changed before its answer");
  a_fetch_ascending_step: assert property (s_read_ack ##1 s_read_req |->
    mem_addr_o == $past(mem_addr_o) + 64'h0000_0000_0000_0008)
    else $error("descriptor fetch address did not step by eight");
  a_write_ack_release: assert property ((mem_req_o && mem_we_o && mem_ack_i) |=> !mem_req_o)
    else $error("write request held after its acknowledge");
  a_error_stops_bus: assert property ((mem_req_o && mem_err_i) |=> !mem_req_o [*4])
    else $error("bus activity continued after an error");
endmodule

bind dmacd_channel dmacd_channel_checker #(.DATA_W(DATA_W)) dmacd_channel_checker_i (
  .sys_clk_i(sys_clk_i),
  .sys_rst_i(sys_rst_i),
  .ce_i(ce_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o),
  .mem_req_o(mem_req_o),
  .mem_we_o(mem_we_o),
  .mem_addr_o(mem_addr_o),
  .mem_wdata_o(mem_wdata_o),
  .mem_ack_i(mem_ack_i),
  .mem_err_i(mem_err_i),
  .irq_o(irq_o)
);

// >>> dv/dmacd_mem_model.sv
// Memory on the internal system bus with settable latency and error injection
`timescale 1ns/1ps
module dmacd_mem_model (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] delay_i,
  input wire logic fail_i,
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [63:0] mem_addr_i,
  input wire logic [63:0] mem_wdata_i,
  output logic [63:0] mem_rdata_o,
  output logic mem_ack_o,
  output logic mem_err_o
);
  logic [63:0] mem [0:127];
  logic [3:0] wait_reg;

  // One answer per request after delay_i cycles; the cycle after an answer is never answered
  // Plain always: the bench preloads and inspects the array directly
  always @(posedge sys_clk_i)
  begin
    mem_ack_o <= 1'b0;
    mem_err_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o; // Stale read data toggles so it cannot pass for fresh data
    if (sys_rst_i)
    begin
      wait_reg <= 4'h0;
      mem_rdata_o <= 64'h5A5A_A5A5_5A5A_A5A5;
    end
    else if (mem_req_i && !mem_ack_o && !mem_err_o)
    begin
      if (wait_reg >= delay_i)
      begin
        wait_reg <= 4'h0;
        if (fail_i)
          mem_err_o <= 1'b1;
        else if (mem_we_i)
          mem[mem_addr_i[9:3]] <= mem_wdata_i;
        else
          mem_rdata_o <= mem[mem_addr_i[9:3]];
        mem_ack_o <= !fail_i;
      end
      else
        wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule

// >>> dv/dmacd_channel_bench.sv
// Self-checking bench: register transfers, bus errors and descriptor chains
`timescale 1ns/1ps
`include "dmacd_defs.svh"
module dmacd_channel_bench;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic mem_req, mem_we, mem_ack, mem_err, irq;
  logic [63:0] mem_addr, mem_wdata, mem_rdata;
  logic [1:0] req_sel;
  logic [3:0] delay = 4'h0;
  logic fail = 1'b0;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  int fetches = 0;

  dmacd_channel #(.DATA_W(64)) dmacd_channel_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .ce_i(1'b1), .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
    .avs_writedata_i(avs_writedata), .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest), .mem_req_o(mem_req), .mem_we_o(mem_we),
    .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata),
    .mem_ack_i(mem_ack), .mem_err_i(mem_err), .irq_o(irq), .req_sel_o(req_sel));
  dmacd_mem_model mem_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .delay_i(delay),
    .fail_i(fail), .mem_req_i(mem_req), .mem_we_i(mem_we), .mem_addr_i(mem_addr),
    .mem_wdata_i(mem_wdata), .mem_rdata_o(mem_rdata), .mem_ack_o(mem_ack), .mem_err_o(mem_err));

  // Clock
  always #4 sys_clk_i = ~sys_clk_i;

  // Watchdog and a count of descriptor words fetched from the descriptor area
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (mem_req && mem_ack && !mem_we && mem_addr[9:8] == 2'h1)
      fetches++;
    if (cycles == 20000)
    begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One register access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk_i);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge sys_clk_i);
    // No local limit: a slave that never answers is caught by the watchdog
    while (avs_waitrequest !== 1'b0)
      @(posedge sys_clk_i);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Upper half first so the pointer's low-half write sees the whole value
  task automatic wr64(input logic [7:0] a, input logic [63:0] v);
    logic [31:0] q;
    bus(1'b1, a + 8'h04, v[63:32], q);
    bus(1'b1, a, v[31:0], q);
  endtask

  task automatic chk(input logic [7:0] a, input logic [63:0] exp);
    logic [31:0] lo, hi;
    bus(1'b0, a, 32'h0, lo);
    bus(1'b0, a + 8'h04, 32'h0, hi);
    cmp({hi, lo}, exp);
  endtask

  task automatic prog(input logic [63:0] s, input logic [63:0] d, input logic [63:0] c);
    wr64(`DMACD_OFF_SRC, s);
    wr64(`DMACD_OFF_DST, d);
    wr64(`DMACD_OFF_CNT, c);
    wr64(`DMACD_OFF_SINC, 64'h8);
    wr64(`DMACD_OFF_DINC, 64'h8);
  endtask

  task automatic put_desc(input int i, input logic [63:0] nx, input logic [63:0] s,
                          input logic [63:0] d, input logic [63:0] c, input logic [63:0] inc,
                          input logic [63:0] ctl);
    mem_i.mem[i] = nx;
    mem_i.mem[i + 1] = s;
    mem_i.mem[i + 2] = d;
    mem_i.mem[i + 3] = c;
    mem_i.mem[i + 4] = inc;
    mem_i.mem[i + 5] = inc;
    mem_i.mem[i + 6] = ctl;
    mem_i.mem[i + 7] = 64'h0;
  endtask

  task automatic wait_irq;
    int n = 0;
    while (irq !== 1'b1 && n < 400)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    cmp({63'h0, irq}, 64'h1);
  endtask

  // Main sequence
  initial
  begin
    logic [31:0] q;
    repeat (3) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    chk(`DMACD_OFF_PTR, 64'h0);
    cmp({63'h0, irq}, 64'h0);
    bus(1'b0, 8'h80, 32'h0, q);
    cmp({32'h0, q}, 64'h0);
    $display("reset test done");
    // Register-only transfer with byte reversal and a slow memory
    mem_i.mem[64] = 64'h0123_4567_90AB_CDEF;
    mem_i.mem[65] = 64'h1122_3344_5566_7788;
    delay <= 4'h3;
    bus(1'b1, `DMACD_OFF_PIN_CONFIG_REG, 32'h2, q);
    bus(1'b1, `DMACD_OFF_MCTRL, 32'h1, q);
    prog(64'h200, 64'h280, 64'h10);
    wr64(`DMACD_OFF_PTR, 64'h0);
    wr64(`DMACD_OFF_STAT, 64'h0);
    wr64(`DMACD_OFF_CTRL, 64'h0B);
    wait_irq();
    cmp(mem_i.mem[80], 64'hEFCD_AB90_6745_2301);
    cmp(mem_i.mem[81], 64'h8877_6655_4433_2211);
    chk(`DMACD_OFF_STAT, 64'h100);
    chk(`DMACD_OFF_CTRL, 64'h0A);
    cmp({62'h0, req_sel}, 64'h2);
    $display("register transfer test done");
    // Read error stops the transfer
    fail <= 1'b1;
    wr64(`DMACD_OFF_STAT, 64'h0);
    prog(64'h200, 64'h280, 64'h8);
    wr64(`DMACD_OFF_CTRL, 64'h11);
    wait_irq();
    fail <= 1'b0;
    chk(`DMACD_OFF_STAT, {60'h0, `DMACD_ERR_RD});
    // Start without master enable: configuration error, nothing moves
    bus(1'b1, `DMACD_OFF_MCTRL, 32'h0, q);
    wr64(`DMACD_OFF_STAT, 64'h0);
    wr64(`DMACD_OFF_CTRL, 64'h01);
    chk(`DMACD_OFF_STAT, {60'h0, `DMACD_ERR_CFG});
    chk(`DMACD_OFF_CTRL, 64'h0);
    bus(1'b1, `DMACD_OFF_MCTRL, 32'h1, q);
    $display("error test done");
    // Two full descriptors; high pointer half alone must not launch
    delay <= 4'h0;
    put_desc(32, 64'h180, 64'h200, 64'h300, 64'h8, 64'h8, 64'h20);
    put_desc(48, 64'h0, 64'h208, 64'h308, 64'h8, 64'h8, 64'h20);
    mem_i.mem[55] = 64'h1000;
    prog(64'h0, 64'h0, 64'h0);
    wr64(`DMACD_OFF_STAT, 64'h0);
    wr64(`DMACD_OFF_CTRL, 64'h20);
    fetches = 0;
    bus(1'b1, `DMACD_OFF_PTR + 8'h04, 32'h1, q);
    repeat (3) @(posedge sys_clk_i);
    cmp({63'h0, mem_req}, 64'h0);
    bus(1'b1, `DMACD_OFF_PTR, 32'h100, q);
    wait_irq();
    cmp(mem_i.mem[96], mem_i.mem[64]);
    cmp(mem_i.mem[97], mem_i.mem[65]);
    chk(`DMACD_OFF_STAT, 64'h1300);
    chk(`DMACD_OFF_PTR, 64'h180);
    cmp(fetches, 64'd16);
    $display("full chain test done");
    // Short descriptor keeps increments and control from launch time
    mem_i.mem[96] = 64'h0;
    mem_i.mem[97] = 64'h0;
    put_desc(32, 64'h0, 64'h200, 64'h300, 64'h10, 64'h0, 64'h02);
    mem_i.mem[39] = 64'h1000;
    prog(64'h0, 64'h0, 64'h0);
    wr64(`DMACD_OFF_STAT, 64'h0);
    wr64(`DMACD_OFF_CTRL, 64'h24);
    fetches = 0;
    wr64(`DMACD_OFF_PTR, 64'h100);
    wait_irq();
    cmp(fetches, 64'd4);
    cmp(mem_i.mem[96], 64'h0123_4567_90AB_CDEF);
    cmp(mem_i.mem[97], 64'h1122_3344_5566_7788);
    chk(`DMACD_OFF_STAT, 64'h300);
    $display("short chain test done");
    test_done();
  end
endmodule
